// [src/clk_gate_pkg.sv]
package clk_gate_pkg;
    localparam int unsigned NUM_DRV = 12;
    localparam int unsigned AW      = 16;
    localparam int unsigned DW      = 8;

    // register byte addresses
    localparam logic [15:0] ADDR_FAULT_STAT = 16'h000C;
    localparam logic [15:0] ADDR_LOCK_STAT  = 16'h000D;
    localparam logic [15:0] ADDR_PIN_CTL    = 16'h0022;
    localparam logic [15:0] ADDR_ASSIGN_LO  = 16'h0023;
    localparam logic [15:0] ADDR_ASSIGN_HI  = 16'h0024;
    localparam logic [15:0] ADDR_ALL_EN     = 16'h0102;
    localparam logic [15:0] ADDR_XTAL_MASK  = 16'h0141;
    localparam logic [15:0] ADDR_LOCK_MASK  = 16'h0142;
    localparam logic [15:0] DRV_EN_OFS [NUM_DRV] = '{
        16'h0103, 16'h0108, 16'h010D, 16'h0112, 16'h0117, 16'h011C,
        16'h0121, 16'h0126, 16'h012B, 16'h0130, 16'h0135, 16'h013A};
    localparam logic [15:0] DRV_CFG_OFS [NUM_DRV] = '{
        16'h0104, 16'h0109, 16'h010E, 16'h0113, 16'h0118, 16'h011D,
        16'h0122, 16'h0127, 16'h012C, 16'h0131, 16'h0136, 16'h013B};

    // field positions
    localparam int unsigned BIT_CAL       = 0;
    localparam int unsigned BIT_XTAL      = 1;
    localparam int unsigned BIT_LOCK      = 1;
    localparam int unsigned BIT_PIN_REG   = 0;
    localparam int unsigned BIT_PIN_SPARE = 1;
    localparam int unsigned BIT_ALL_EN    = 0;
    localparam int unsigned BIT_DRV_EN    = 1;
    localparam int unsigned BIT_SYNC      = 3;
    localparam int unsigned BIT_LVL       = 4;
    localparam int unsigned BIT_XTAL_MASK = 6;
    localparam int unsigned BIT_LOCK_MASK = 1;

    // reset values and encodings
    localparam logic        RST_ENABLE = 1'b0;
    localparam logic        RST_MASK   = 1'b0;
    localparam logic        RST_SYNC   = 1'b0;
    localparam logic        RST_PIN_REG = 1'b1;
    localparam logic [11:0] RST_ASSIGN = 12'hFFF;
    localparam logic [1:0]  LVL_LOW    = 2'h0;
    localparam logic [1:0]  LVL_HIGH   = 2'h1;

    typedef struct packed {
        logic       sync_sel;
        logic [1:0] level;
        logic       drv_en;
    } drv_cfg_t;

    typedef struct packed {
        logic calib;
        logic xtal;
        logic lock;
        logic pin_off;
    } fault_t;
endpackage

// [src/clock_output_enable_gating.sv]
module clock_output_enable_gating (
    // clock, reset, clock enable
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    // register port
    input  wire logic [clk_gate_pkg::AW-1:0] reg_addr,
    input  wire logic                        reg_wr,
    input  wire logic [clk_gate_pkg::DW-1:0] reg_wdata,
    input  wire logic                        reg_rd,
    output logic      [clk_gate_pkg::DW-1:0] reg_rdata,
    output logic                             reg_rvalid,
    // device pins and fault inputs, asynchronous to mclk
    input  wire logic                        ext_enable_n_pin,
    input  wire logic                        lock_loss_in,
    input  wire logic                        crystal_fail_in,
    input  wire logic                        calibration_active_in,
    input  wire logic [clk_gate_pkg::NUM_DRV-1:0] src_clk,
    // gated driver outputs
    output logic      [clk_gate_pkg::NUM_DRV-1:0] drv_out,
    output logic      [clk_gate_pkg::NUM_DRV-1:0] drv_active
);
    import clk_gate_pkg::*;

    localparam int unsigned NPIN = NUM_DRV + 4;

    // synchroniser stages and edge history
    logic [NPIN-1:0]    meta_q;
    logic [NPIN-1:0]    sync_q;
    logic [NUM_DRV-1:0] src_prev_q;
    logic [NUM_DRV-1:0] src_s;
    logic [NUM_DRV-1:0] rise;
    fault_t             fault;

    // control registers
    logic               all_en_q;
    logic               xtal_mask_q;
    logic               lock_mask_q;
    logic               pin_reg_q;
    logic               pin_spare_q;
    logic [11:0]        assign_q;
    drv_cfg_t           cfg_q [NUM_DRV];

    // gating state
    logic [NUM_DRV-1:0] req;
    logic [NUM_DRV-1:0] en_nxt;
    logic [NUM_DRV-1:0] en_q;
    logic [NUM_DRV-1:0] out_q;
    logic [NUM_DRV-1:0] lvl;
    logic               global_ok;

    // read path
    logic [DW-1:0]      rdata_d;
    logic [DW-1:0]      rdata_q;
    logic               rvalid_q;

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce) begin
            meta_q <= {calibration_active_in, crystal_fail_in,
                       lock_loss_in, ext_enable_n_pin, src_clk};
            sync_q <= meta_q;
        end
    end

    // driver clocks after resync, with one more stage for edge detect
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            src_prev_q <= '0;
        end else if (ce) begin
            src_prev_q <= src_s;
        end
    end

    assign src_s         = sync_q[NUM_DRV-1:0];
    assign rise          = src_s & ~src_prev_q; // period boundary
    assign fault.pin_off = sync_q[NUM_DRV];
    assign fault.lock    = sync_q[NUM_DRV+1];
    assign fault.xtal    = sync_q[NUM_DRV+2]; // crystal fault
    assign fault.calib   = sync_q[NUM_DRV+3];

    // global control writes; unmapped addresses are ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            all_en_q    <= RST_ENABLE;
            xtal_mask_q <= RST_MASK;
            lock_mask_q <= RST_MASK;
            pin_reg_q   <= RST_PIN_REG;
            pin_spare_q <= 1'b0;
            assign_q    <= RST_ASSIGN;
        end else if (ce && reg_wr) begin
            if (reg_addr == ADDR_ALL_EN) begin
                all_en_q <= reg_wdata[BIT_ALL_EN];
            end else if (reg_addr == ADDR_XTAL_MASK) begin
                xtal_mask_q <= reg_wdata[BIT_XTAL_MASK];
            end else if (reg_addr == ADDR_LOCK_MASK) begin
                lock_mask_q <= reg_wdata[BIT_LOCK_MASK];
            end else if (reg_addr == ADDR_PIN_CTL) begin
                pin_reg_q   <= reg_wdata[BIT_PIN_REG];
                pin_spare_q <= reg_wdata[BIT_PIN_SPARE];
            end else if (reg_addr == ADDR_ASSIGN_LO) begin
                assign_q[7:0] <= reg_wdata;
            end else if (reg_addr == ADDR_ASSIGN_HI) begin
                assign_q[11:8] <= reg_wdata[3:0];
            end
        end
    end

    // every non-driver source except the enable pin and its register bit pin_reg_q is shared by all drivers
    assign global_ok = all_en_q
                     & ~(fault.lock & ~lock_mask_q)
                     & ~(fault.xtal & ~xtal_mask_q)
                     & ~fault.calib;

    // per-driver configuration, request and gating
    for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv

        // driver enable byte and mode/level byte
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                cfg_q[i].drv_en   <= RST_ENABLE;
                cfg_q[i].sync_sel <= RST_SYNC;
                cfg_q[i].level    <= LVL_LOW;
            end else if (ce && reg_wr) begin
                if (reg_addr == DRV_EN_OFS[i]) begin
                    cfg_q[i].drv_en <= reg_wdata[BIT_DRV_EN];
                end else if (reg_addr == DRV_CFG_OFS[i]) begin
                    cfg_q[i].sync_sel <= reg_wdata[BIT_SYNC];
                    cfg_q[i].level    <= reg_wdata[BIT_LVL+1:BIT_LVL];
                end
            end
        end

        // any one unmasked source that reaches this driver (the pin only where assign_q is set) is enough to stop it
        assign req[i] = global_ok & cfg_q[i].drv_en
                      & ~(assign_q[i]
                          & (fault.pin_off | ~pin_reg_q));

        // reserved level codes hold low, so only code 1 drives high
        assign lvl[i] = (cfg_q[i].level == LVL_HIGH);

        // mode choice covers manual and automatic changes alike
        assign en_nxt[i] = (cfg_q[i].sync_sel && !rise[i])
                         ? en_q[i]
                         : req[i];

        // enable state; in sync mode it moves only at a rising edge
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                en_q[i] <= RST_ENABLE;
            end else if (ce) begin
                en_q[i] <= en_nxt[i];
            end
        end

        // output follows the clock or holds the static level
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                out_q[i] <= 1'b0;
            end else if (ce) begin
                out_q[i] <= en_nxt[i] ? src_s[i] : lvl[i];
            end
        end
    end

    // read decode; reserved bits read zero
    always_comb begin
        rdata_d = '0;
        if (reg_addr == ADDR_FAULT_STAT) begin
            rdata_d[BIT_CAL]  = fault.calib;
            rdata_d[BIT_XTAL] = fault.xtal;
        end else if (reg_addr == ADDR_LOCK_STAT) begin
            rdata_d[BIT_LOCK] = fault.lock;
        end else if (reg_addr == ADDR_PIN_CTL) begin
            rdata_d[BIT_PIN_REG]   = pin_reg_q;
            rdata_d[BIT_PIN_SPARE] = pin_spare_q;
        end else if (reg_addr == ADDR_ASSIGN_LO) begin
            rdata_d = assign_q[7:0];
        end else if (reg_addr == ADDR_ASSIGN_HI) begin
            rdata_d[3:0] = assign_q[11:8];
        end else if (reg_addr == ADDR_ALL_EN) begin
            rdata_d[BIT_ALL_EN] = all_en_q;
        end else if (reg_addr == ADDR_XTAL_MASK) begin
            rdata_d[BIT_XTAL_MASK] = xtal_mask_q;
        end else if (reg_addr == ADDR_LOCK_MASK) begin
            rdata_d[BIT_LOCK_MASK] = lock_mask_q;
        end else begin
            for (int k = 0; k < NUM_DRV; k++) begin
                if (reg_addr == DRV_EN_OFS[k]) begin
                    rdata_d[BIT_DRV_EN] = cfg_q[k].drv_en;
                end else if (reg_addr == DRV_CFG_OFS[k]) begin
                    rdata_d[BIT_SYNC]            = cfg_q[k].sync_sel;
                    rdata_d[BIT_LVL+1:BIT_LVL]   = cfg_q[k].level;
                end
            end
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else if (ce) begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign drv_out    = out_q;
    assign drv_active = en_q;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence boundary_hit(logic sel, logic edge_seen);
        ce && sel && edge_seen;
    endsequence

    sequence between_edges(logic sel, logic edge_seen);
        ce && sel && !edge_seen;
    endsequence

    // two edges with the clock enable high, outside reset
    sequence live_pair;
        !rst && ce ##1 ce;
    endsequence

    for (genvar j = 0; j < NUM_DRV; j++) begin : g_chk
        chk_sync_hold_mid: assert property (
            between_edges(cfg_q[j].sync_sel, rise[j])
            |=> en_q[j] == $past(en_q[j]))
            else $error("sync driver changed mid period");

        chk_sync_edge_take: assert property (
            boundary_hit(cfg_q[j].sync_sel, rise[j])
            |=> en_q[j] == $past(req[j]))
            else $error("sync driver missed boundary");

        chk_async_immediate: assert property (
            (ce && !cfg_q[j].sync_sel) |=> en_q[j] == $past(req[j]))
            else $error("async driver did not follow request");

        chk_disabled_level: assert property (
            (ce && !en_nxt[j])
            |=> !en_q[j] && out_q[j] == $past(lvl[j]))
            else $error("disabled driver not at static level");

        chk_enabled_clock: assert property (
            (ce && en_nxt[j]) |=> out_q[j] == $past(src_s[j]))
            else $error("enabled driver not following clock");

        chk_level_code: assert property (
            (ce && !en_nxt[j] && cfg_q[j].level != LVL_HIGH) |=> !out_q[j])
            else $error("reserved level code drives high");

        chk_pin_disable: assert property (
            (assign_q[j] && (fault.pin_off || !pin_reg_q)) |-> !req[j])
            else $error("enable pin did not disable driver");

        chk_drv_en_disable: assert property (
            (!cfg_q[j].drv_en) |-> !req[j])
            else $error("driver enable bit ignored");

        chk_wr_drv_en: assert property (
            (ce && reg_wr && reg_addr == DRV_EN_OFS[j])
            |=> cfg_q[j].drv_en == $past(reg_wdata[BIT_DRV_EN]))
            else $error("driver enable write lost");

        chk_wr_sync_sel: assert property (
            (ce && reg_wr && reg_addr == DRV_CFG_OFS[j])
            |=> cfg_q[j].sync_sel == $past(reg_wdata[BIT_SYNC]))
            else $error("mode select write lost");

        chk_wr_level: assert property (
            (ce && reg_wr && reg_addr == DRV_CFG_OFS[j])
            |=> cfg_q[j].level == $past(reg_wdata[BIT_LVL+1:BIT_LVL]))
            else $error("level write lost");

        // a masked fault alone must leave a wanted driver running
        chk_lock_masked_run: assert property (
            (fault.lock && lock_mask_q && all_en_q && cfg_q[j].drv_en
             && !fault.calib && (xtal_mask_q || !fault.xtal)
             && !(assign_q[j] && (fault.pin_off || !pin_reg_q)))
            |-> req[j])
            else $error("masked lock loss stopped driver");

        chk_xtal_masked_run: assert property (
            (fault.xtal && xtal_mask_q && all_en_q && cfg_q[j].drv_en
             && !fault.calib && (lock_mask_q || !fault.lock)
             && !(assign_q[j] && (fault.pin_off || !pin_reg_q)))
            |-> req[j])
            else $error("masked crystal loss stopped driver");
    end

    chk_lock_loss_off: assert property (
        (fault.lock && !lock_mask_q) |-> req == '0)
        else $error("lock loss did not disable drivers");

    chk_xtal_loss_off: assert property (
        (fault.xtal && !xtal_mask_q) |-> req == '0)
        else $error("crystal loss did not disable drivers");

    chk_calib_off: assert property (
        fault.calib |-> req == '0)
        else $error("calibration did not disable drivers");

    chk_global_off: assert property (
        !all_en_q |-> req == '0)
        else $error("global enable low did not disable drivers");

    chk_all_clear_run: assert property (
        (all_en_q && !fault.calib && !fault.pin_off && pin_reg_q
         && !fault.lock && !fault.xtal && cfg_q[0].drv_en) |-> req[0])
        else $error("driver disabled with no active source");

    chk_read_answer: assert property (
        (ce && reg_rd) |=> reg_rvalid && reg_rdata == $past(rdata_d))
        else $error("read answer wrong or late");

    // strobes and state freeze while the clock enable is low
    chk_ce_freeze: assert property (
        !ce |=> en_q == $past(en_q) && out_q == $past(out_q)
                && sync_q == $past(sync_q)
                && reg_rvalid == $past(reg_rvalid))
        else $error("state moved with clock enable low");

    chk_rvalid_pulse: assert property (
        (ce && !reg_rd) |=> !reg_rvalid)
        else $error("read answer without a read");

    chk_wr_all_en: assert property (
        (ce && reg_wr && reg_addr == ADDR_ALL_EN)
        |=> all_en_q == $past(reg_wdata[BIT_ALL_EN]))
        else $error("global enable write lost");

    chk_wr_lock_mask: assert property (
        (ce && reg_wr && reg_addr == ADDR_LOCK_MASK)
        |=> lock_mask_q == $past(reg_wdata[BIT_LOCK_MASK]))
        else $error("lock mask write lost");

    chk_wr_xtal_mask: assert property (
        (ce && reg_wr && reg_addr == ADDR_XTAL_MASK)
        |=> xtal_mask_q == $past(reg_wdata[BIT_XTAL_MASK]))
        else $error("crystal mask write lost");

    // status bits read back the synchronised fault levels
    chk_lock_status: assert property (
        (ce && reg_rd && reg_addr == ADDR_LOCK_STAT)
        |=> reg_rdata[BIT_LOCK] == $past(fault.lock))
        else $error("lock status bit wrong");

    chk_fault_status: assert property (
        (ce && reg_rd && reg_addr == ADDR_FAULT_STAT)
        |=> reg_rdata[BIT_XTAL] == $past(fault.xtal)
            && reg_rdata[BIT_CAL] == $past(fault.calib))
        else $error("fault status bits wrong");

    // each pin reaches the gating logic two live edges after it moves
    chk_pin_path: assert property (
        live_pair |=> fault.pin_off == $past(ext_enable_n_pin, 2))
        else $error("enable pin path wrong");

    chk_lock_path: assert property (
        live_pair |=> fault.lock == $past(lock_loss_in, 2))
        else $error("lock loss path wrong");

    chk_xtal_path: assert property (
        live_pair |=> fault.xtal == $past(crystal_fail_in, 2))
        else $error("crystal fault path wrong");

    chk_calib_path: assert property (
        live_pair |=> fault.calib == $past(calibration_active_in, 2))
        else $error("calibration path wrong");

endmodule // clock_output_enable_gating

// [tb/clock_source_model.sv]
module clock_source_model (
    // ungated source clocks, one per driver
    output logic [clk_gate_pkg::NUM_DRV-1:0] src_clk
);
    timeunit 1ns;
    timeprecision 1ns;

    // free running, unrelated phases, each slower than mclk/4
    // keeps running through lock loss like the real pll
    for (genvar g = 0; g < clk_gate_pkg::NUM_DRV; g++) begin : gen_src
        initial begin
            src_clk[g] = 1'b0;
            forever #(130 + 17 * g) src_clk[g] = ~src_clk[g];
        end
    end
endmodule // clock_source_model

// [tb/tb_clock_output_enable_gating.sv]
module tb_clock_output_enable_gating import clk_gate_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic               mclk, rst, ce, reg_wr, reg_rd, reg_rvalid;
    logic               ext_enable_n_pin, lock_loss_in, crystal_fail_in;
    logic               calibration_active_in, glob, pinreg, mlol, mx;
    logic [AW-1:0]      reg_addr;
    logic [DW-1:0]      reg_wdata, reg_rdata;
    logic [NUM_DRV-1:0] src_clk, drv_out, drv_active, asg, pa, po;
    drv_cfg_t           cfg [NUM_DRV];
    int                 fails, cmp_count, cyc, d;
    integer             seed = 32'he7cd2bf3;
    localparam logic [15:0] ST_A [3] = '{ADDR_LOCK_STAT, ADDR_FAULT_STAT,
                                         ADDR_FAULT_STAT};
    localparam logic [7:0]  ST_V [3] = '{8'h02, 8'h02, 8'h01};

    clock_source_model u_clock_source_model (.src_clk(src_clk));

    clock_output_enable_gating u_clock_output_enable_gating (
        .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .ext_enable_n_pin(ext_enable_n_pin), .lock_loss_in(lock_loss_in),
        .crystal_fail_in(crystal_fail_in),
        .calibration_active_in(calibration_active_in),
        .src_clk(src_clk), .drv_out(drv_out), .drv_active(drv_active));

    // expected enable state from the combined disable sources
    function automatic logic [NUM_DRV-1:0] exp_act();
        logic [NUM_DRV-1:0] a;
        for (int i = 0; i < NUM_DRV; i++)
            a[i] = glob & cfg[i].drv_en & ~calibration_active_in
                 & ~(asg[i] & (ext_enable_n_pin | ~pinreg))
                 & ~(lock_loss_in & ~mlol) & ~(crystal_fail_in & ~mx);
        return a;
    endfunction

    // static level expected on each disabled driver
    function automatic logic [NUM_DRV-1:0] hi_vec();
        logic [NUM_DRV-1:0] a;
        for (int i = 0; i < NUM_DRV; i++)
            a[i] = (cfg[i].level == LVL_HIGH);
        return a;
    endfunction

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp,
                       input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e,
                      input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk({11'h0, reg_rvalid}, 12'h001, "read valid");
        chk({4'h0, reg_rdata}, {4'h0, e}, what);
        @(posedge mclk);
        #1;
        chk({11'h0, reg_rvalid}, 12'h000, "read valid end");
    endtask

    task automatic wr_cfg(input int i);
        wr(DRV_CFG_OFS[i], {2'b00, cfg[i].level, cfg[i].sync_sel, 3'b000});
    endtask

    task automatic wr_en(input int i);
        wr(DRV_EN_OFS[i], {6'h00, cfg[i].drv_en, 1'b0});
    endtask

    task automatic set_flt(input logic [2:0] v);
        @(posedge mclk);
        lock_loss_in          <= v[0];
        crystal_fail_in       <= v[1];
        calibration_active_in <= v[2];
    endtask

    // bounded wait for the expected state, then compare state and levels
    task automatic settle(input int lim, input string what);
        int n;
        n = 0;
        #1;
        while (drv_active !== exp_act() && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(drv_active, exp_act(), what);
        chk(drv_out & ~exp_act(), hi_vec() & ~exp_act(), what);
        // a late wrong move must not slip past an early match
        repeat (4) @(posedge mclk);
        #1;
        chk(drv_active, exp_act(), what);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // sync drivers may only switch on a rising source edge: no runt
    always @(posedge mclk) begin
        #1;
        for (int i = 0; i < NUM_DRV; i++)
            if (!rst && cfg[i].sync_sel && drv_active[i] !== pa[i])
                chk({11'h0, drv_active[i] ? drv_out[i] : po[i]},
                    {11'h0, drv_active[i]}, "sync edge");
        pa = drv_active;
        po = drv_out;
    end

    // hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        {rst, ce, pinreg, asg} = {3'b111, 12'hFFF};
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {ext_enable_n_pin, lock_loss_in, crystal_fail_in} = '0;
        {calibration_active_in, glob, mlol, mx, pa, po} = '0;
        {fails, cmp_count, cyc} = '0;
        for (int i = 0; i < NUM_DRV; i++)
            cfg[i] = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        // register defaults and an unmapped read
        rd(ADDR_ALL_EN, 8'h00, "all enable");
        for (int i = 0; i < NUM_DRV; i++) begin
            rd(DRV_EN_OFS[i], 8'h00, "driver enable");
            rd(DRV_CFG_OFS[i], 8'h00, "sync select");
        end
        rd(ADDR_LOCK_MASK, 8'h00, "lock mask");
        rd(ADDR_XTAL_MASK, 8'h00, "crystal mask");
        rd(ADDR_PIN_CTL, 8'h01, "pin ctl");
        rd(ADDR_ASSIGN_LO, 8'hFF, "assign lo");
        rd(ADDR_ASSIGN_HI, 8'h0F, "assign hi");
        rd(16'h0200, 8'h00, "unmapped");
        settle(2, "reset state");
        $display("test reset done");
        // asynchronous drivers follow writes at once, every level code
        glob = 1'b1;
        wr(ADDR_ALL_EN, 8'h01);
        for (int i = 0; i < NUM_DRV; i++) begin
            cfg[i].drv_en = 1'b1;
            wr_en(i);
        end
        settle(2, "all on");
        for (int k = 0; k < 8; k++) begin
            d = $unsigned($random(seed)) % NUM_DRV;
            cfg[d].level = k[1:0];
            wr_cfg(d);
            cfg[d].drv_en = 1'b0;
            wr_en(d);
            settle(2, "async off");
            cfg[d].drv_en = 1'b1;
            wr_en(d);
            settle(2, "async on");
        end
        $display("test async done");
        // synchronous drivers, manual and fault-driven changes
        for (int i = 0; i < NUM_DRV; i++) begin
            cfg[i].sync_sel = 1'b1;
            wr_cfg(i);
        end
        for (int k = 0; k < 6; k++) begin
            d = $unsigned($random(seed)) % NUM_DRV;
            cfg[d].drv_en = 1'b0;
            wr_en(d);
            settle(40, "sync off");
            cfg[d].drv_en = 1'b1;
            wr_en(d);
            settle(40, "sync on");
        end
        set_flt(3'b001);
        settle(40, "sync fault");
        set_flt(3'b000);
        settle(40, "sync fault end");
        for (int i = 0; i < NUM_DRV; i++) begin
            cfg[i].sync_sel = 1'b0;
            wr_cfg(i);
        end
        $display("test sync done");
        // each fault alone, status bits, then masking
        for (int f = 0; f < 3; f++) begin
            set_flt(3'b001 << f);
            settle(5, "fault");
            rd(ST_A[f], ST_V[f], "fault status");
            set_flt(3'b000);
            settle(5, "fault end");
        end
        {mlol, mx} = 2'b11;
        wr(ADDR_LOCK_MASK, 8'h02);
        wr(ADDR_XTAL_MASK, 8'h40);
        set_flt(3'b011);
        settle(5, "masked");
        set_flt(3'b111);
        settle(5, "calibration");
        set_flt(3'b000);
        settle(5, "no fault");
        $display("test faults done");
        // pin and enable register bit on a random assignment
        asg = 12'($random(seed));
        wr(ADDR_ASSIGN_LO, asg[7:0]);
        wr(ADDR_ASSIGN_HI, {4'h0, asg[11:8]});
        @(posedge mclk) ext_enable_n_pin <= 1'b1;
        settle(5, "pin high");
        @(posedge mclk) ext_enable_n_pin <= 1'b0;
        settle(5, "pin low");
        pinreg = 1'b0;
        wr(ADDR_PIN_CTL, 8'h00);
        settle(5, "enable bit");
        pinreg = 1'b1;
        wr(ADDR_PIN_CTL, 8'h01);
        glob = 1'b0;
        wr(ADDR_ALL_EN, 8'h00);
        settle(2, "global off");
        glob = 1'b1;
        wr(ADDR_ALL_EN, 8'h01);
        settle(5, "global on");
        $display("test pin done");
        // a write under a low clock enable is ignored
        @(posedge mclk) ce <= 1'b0;
        wr(ADDR_ALL_EN, 8'h00);
        @(posedge mclk) ce <= 1'b1;
        rd(ADDR_ALL_EN, 8'h01, "ce hold");
        settle(2, "ce state");
        $display("test ce done");
        // mid-run reset brings every control back to its default
        @(posedge mclk) rst <= 1'b1;
        @(posedge mclk) rst <= 1'b0;
        #1;
        chk(drv_active, 12'h000, "reset active");
        chk(drv_out, 12'h000, "reset out");
        {glob, mlol, mx} = '0;
        asg = 12'hFFF;
        for (int i = 0; i < NUM_DRV; i++)
            cfg[i] = '0;
        rd(DRV_CFG_OFS[3], 8'h00, "reset sync select");
        rd(ADDR_LOCK_MASK, 8'h00, "reset lock mask");
        rd(ADDR_ASSIGN_LO, 8'hFF, "reset assign lo");
        settle(2, "reset again");
        $display("test reset again done");
        report_and_stop();
    end
endmodule // tb_clock_output_enable_gating
